// ==== rtl/rtc_rule_table_cache.sv ====
// Rule table staging caches, move configuration and row update engine
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// Operation
// - Move distance in bits 31:16 moves rows by value plus one.
// - Row count n in bits 15:0 covers update address through address+n.
// - Row count also sets how many rows an initialise fills.
// - Entry cache is 32 words at stride 4, word 0 least significant.
// - Mask cache is 32 words from 0x80, word 0 least significant.
// - Action cache is 32 words from 0x100, word 0 least significant.
// - Counter cache is 32 words from 0x180, word 0 least significant.
// - Caches hold flops only up to their physical row width.
// - Type-group word at 0x200 packs subwords, subword 0 lowest.
// - All cache words and both move fields reset to zero.
// - Commands: 0 to memory, 1 from memory, 2 up, 3 down, 4 init.
// - Move up lowers row address by distance, move down raises it.
// - Row moved below address zero is invalidated, action/counter zeroed.
// - Trigger bit starts operation; hardware clears it on completion.
module rtc_rule_table_cache
  import rtc_pkg::*;
#(
  parameter int ROWS = 16,
  parameter int ENTRY_W = 64,
  parameter int ACTION_W = 64,
  parameter int CNT_W = 32,
  parameter int TG_W = 8,
  parameter int SUBWORDS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int TGT_W = TG_W * SUBWORDS;
  localparam int RW = $clog2(ROWS);
  localparam logic [17:0] ROWS18 = 18'(ROWS);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [2:0] region(input logic [11:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] != 2'h0) begin
      s = SEL_NONE;
    end else if (a < OFS_MASK) begin
      s = SEL_ENTRY;
    end else if (a < OFS_ACTION) begin
      s = SEL_MASK;
    end else if (a < OFS_CNT) begin
      s = SEL_ACTION;
    end else if (a < OFS_CNT + GRP_SPAN) begin
      s = SEL_CNT;
    end else if (a == OFS_TG) begin
      s = SEL_TG;
    end else if (a == OFS_MV_CFG) begin
      s = SEL_MV;
    end else if (a == OFS_UPD_CTRL) begin
      s = SEL_CTRL;
    end
    return s;
  endfunction : region

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [15:0] move_distance_r;
  logic [15:0] move_row_count_r;
  logic [2:0] cmd_r;
  logic entry_dis_r;
  logic action_dis_r;
  logic cnt_dis_r;
  logic [15:0] upd_addr_r;
  logic shot_r;
  logic clear_r;
  logic [15:0] step_r;
  rtc_state_t state_r;

  logic [ENTRY_W-1:0] mem_entry [ROWS];
  logic [ENTRY_W-1:0] mem_mask [ROWS];
  logic [TGT_W-1:0] mem_tg [ROWS];
  logic mem_valid [ROWS];
  logic [ACTION_W-1:0] mem_action [ROWS];
  logic [CNT_W-1:0] mem_cnt [ROWS];

  ////////////////////////////////////////////////////////////////////////
  // Bus side

  wire [2:0] sel = region(paddr);
  wire [4:0] widx = paddr[6:2];
  wire first_acc = psel & penable & ~pready_r;
  wire commit = psel & penable & pready_r;
  wire wr_commit = commit & pwrite & (sel != SEL_NONE);
  wire busy = (state_r == ST_RUN) | shot_r;

  wire [31:0] mv_word = {move_distance_r, move_row_count_r};
  wire [31:0] ctrl_word = {7'h0, cmd_r, entry_dis_r, action_dis_r,
                           cnt_dis_r, upd_addr_r, shot_r, clear_r, 1'b0};
  wire [31:0] mv_new = merge(mv_word, pwdata, pstrb);
  wire [31:0] ctrl_new = merge(ctrl_word, pwdata, pstrb);

  wire [31:0] rd_entry;
  wire [31:0] rd_mask;
  wire [31:0] rd_action;
  wire [31:0] rd_cnt;
  wire [31:0] rd_tg;
  wire [ENTRY_W-1:0] c_entry;
  wire [ENTRY_W-1:0] c_mask;
  wire [ACTION_W-1:0] c_action;
  wire [CNT_W-1:0] c_cnt;
  wire [TGT_W-1:0] c_tg;

  wire [31:0] rd_mux =
    (sel == SEL_ENTRY) ? rd_entry :
    (sel == SEL_MASK) ? rd_mask :
    (sel == SEL_ACTION) ? rd_action :
    (sel == SEL_CNT) ? rd_cnt :
    (sel == SEL_TG) ? rd_tg :
    (sel == SEL_MV) ? mv_word :
    (sel == SEL_CTRL) ? ctrl_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= first_acc;
      prdata_r <= (first_acc && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_r <= first_acc && (sel == SEL_NONE);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // Row engine datapath

  wire running = (state_r == ST_RUN);
  wire is_to = (cmd_r == CMD_TO_MEM);
  wire is_from = (cmd_r == CMD_FROM_MEM);
  wire is_up = (cmd_r == CMD_MOVE_UP);
  wire is_down = (cmd_r == CMD_MOVE_DOWN);
  wire is_init = (cmd_r == CMD_INIT);
  wire [17:0] addr18 = {2'h0, upd_addr_r};
  wire [17:0] rows18 = {2'h0, move_row_count_r};
  wire [17:0] step18 = {2'h0, step_r};
  wire [17:0] dist1 = {2'h0, move_distance_r} + 18'h1;
  // Down moves walk from the far end so no source is overwritten early
  wire [17:0] src = is_down ? addr18 + rows18 - step18 :
                              addr18 + step18;
  wire underflow = is_up && (src < dist1);
  wire [17:0] dst = is_up ? (underflow ? src : src - dist1) :
                    is_down ? src + dist1 : src;
  wire src_ok = src < ROWS18;
  wire dst_ok = dst < ROWS18;
  wire [RW-1:0] src_i = src[RW-1:0];
  wire [RW-1:0] dst_i = dst[RW-1:0];
  wire is_move = is_up | is_down;
  wire last = is_to | is_from | (step_r == move_row_count_r) |
              !(is_move | is_init);

  wire [ENTRY_W-1:0] r_entry = src_ok ? mem_entry[src_i] : '0;
  wire [ENTRY_W-1:0] r_mask = src_ok ? mem_mask[src_i] : '0;
  wire [TGT_W-1:0] r_tg = src_ok ? mem_tg[src_i] : '0;
  wire r_valid = src_ok ? mem_valid[src_i] : 1'b0;
  wire [ACTION_W-1:0] r_action = src_ok ? mem_action[src_i] : '0;
  wire [CNT_W-1:0] r_cnt = src_ok ? mem_cnt[src_i] : '0;

  wire mwr = running & dst_ok & (is_to | is_init | is_move);
  wire we_entry = mwr & ~entry_dis_r;
  wire we_action = mwr & ~action_dis_r;
  wire we_cnt = mwr & ~cnt_dis_r;
  wire w_valid = is_move ? (r_valid & ~underflow) : 1'b1;
  wire [ENTRY_W-1:0] w_entry = is_move ? r_entry : c_entry;
  wire [ENTRY_W-1:0] w_mask = is_move ? r_mask : c_mask;
  wire [TGT_W-1:0] w_tg = is_move ? r_tg : c_tg;
  wire [ACTION_W-1:0] w_action = is_move ?
    (underflow ? '0 : r_action) : c_action;
  wire [CNT_W-1:0] w_cnt = is_move ?
    (underflow ? '0 : r_cnt) : c_cnt;

  wire ld = running & is_from;
  wire ld_entry = ld & ~entry_dis_r;
  wire ld_action = ld & ~action_dis_r;
  wire ld_cnt = ld & ~cnt_dis_r;

  always_ff @(posedge clk) begin
    if (we_entry) begin
      mem_entry[dst_i] <= w_entry;
      mem_mask[dst_i] <= w_mask;
      mem_tg[dst_i] <= w_tg;
      mem_valid[dst_i] <= w_valid;
    end
    if (we_action) begin
      mem_action[dst_i] <= w_action;
    end
    if (we_cnt) begin
      mem_cnt[dst_i] <= w_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration, trigger and sequencer

  wire mv_wr = wr_commit & (sel == SEL_MV) & ~busy;
  wire ctrl_wr = wr_commit & (sel == SEL_CTRL) & ~busy;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      move_distance_r <= MV_CFG_RST[31:16];
      move_row_count_r <= MV_CFG_RST[15:0];
    end else if (mv_wr) begin
      move_distance_r <= mv_new[MV_DIST_LSB +: 16];
      move_row_count_r <= mv_new[MV_ROWS_LSB +: 16];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_r <= UPD_CTRL_RST[CTRL_CMD_LSB +: 3];
      entry_dis_r <= 1'b0;
      action_dis_r <= 1'b0;
      cnt_dis_r <= 1'b0;
      upd_addr_r <= 16'h0000;
      clear_r <= 1'b0;
    end else if (ctrl_wr) begin
      cmd_r <= ctrl_new[CTRL_CMD_LSB +: 3];
      entry_dis_r <= ctrl_new[CTRL_ENTRY_DIS];
      action_dis_r <= ctrl_new[CTRL_ACTION_DIS];
      cnt_dis_r <= ctrl_new[CTRL_CNT_DIS];
      upd_addr_r <= ctrl_new[CTRL_ADDR_LSB +: 16];
      clear_r <= ctrl_new[CTRL_CLEAR];
    end else begin
      clear_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shot_r <= 1'b0;
      state_r <= ST_IDLE;
      step_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (ctrl_wr) begin
            shot_r <= ctrl_new[CTRL_SHOT];
          end else if (shot_r) begin
            state_r <= ST_RUN;
            step_r <= 16'h0000;
          end
        end
        ST_RUN: begin
          if (last) begin
            shot_r <= 1'b0;
            state_r <= ST_IDLE;
            step_r <= 16'h0000;
          end else begin
            step_r <= step_r + 16'h0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Caches

  wire cwr = wr_commit & ~running;

  rtc_cache_bank #(.W(ENTRY_W)) u_entry (
    .clk(clk), .sys_rst(sys_rst),
    .wr_en(cwr & (sel == SEL_ENTRY)), .wr_idx(widx),
    .wr_data(pwdata), .wr_strb(pstrb),
    .ld_en(ld_entry), .ld_data(r_entry), .clr(clear_r),
    .rd_idx(widx), .rd_data(rd_entry), .value(c_entry)
  );

  rtc_cache_bank #(.W(ENTRY_W)) u_mask (
    .clk(clk), .sys_rst(sys_rst),
    .wr_en(cwr & (sel == SEL_MASK)), .wr_idx(widx),
    .wr_data(pwdata), .wr_strb(pstrb),
    .ld_en(ld_entry), .ld_data(r_mask), .clr(clear_r),
    .rd_idx(widx), .rd_data(rd_mask), .value(c_mask)
  );

  rtc_cache_bank #(.W(ACTION_W)) u_action (
    .clk(clk), .sys_rst(sys_rst),
    .wr_en(cwr & (sel == SEL_ACTION)), .wr_idx(widx),
    .wr_data(pwdata), .wr_strb(pstrb),
    .ld_en(ld_action), .ld_data(r_action), .clr(clear_r),
    .rd_idx(widx), .rd_data(rd_action), .value(c_action)
  );

  rtc_cache_bank #(.W(CNT_W)) u_cnt (
    .clk(clk), .sys_rst(sys_rst),
    .wr_en(cwr & (sel == SEL_CNT)), .wr_idx(widx),
    .wr_data(pwdata), .wr_strb(pstrb),
    .ld_en(ld_cnt), .ld_data(r_cnt), .clr(clear_r),
    .rd_idx(widx), .rd_data(rd_cnt), .value(c_cnt)
  );

  // Subword 0 sits in the low bits of the single word
  rtc_cache_bank #(.W(TGT_W)) u_tg (
    .clk(clk), .sys_rst(sys_rst),
    .wr_en(cwr & (sel == SEL_TG)), .wr_idx(5'h00),
    .wr_data(pwdata), .wr_strb(pstrb),
    .ld_en(ld_entry), .ld_data(r_tg), .clr(clear_r),
    .rd_idx(5'h00), .rd_data(rd_tg), .value(c_tg)
  );

endmodule : rtc_rule_table_cache

// ==== rtl/rtc_pkg.sv ====
// Constants shared by the rule table cache and move configuration block
package rtc_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_ENTRY = 12'h000;
  localparam logic [11:0] OFS_MASK = 12'h080;
  localparam logic [11:0] OFS_ACTION = 12'h100;
  localparam logic [11:0] OFS_CNT = 12'h180;
  localparam logic [11:0] OFS_TG = 12'h200;
  localparam logic [11:0] OFS_MV_CFG = 12'h210;
  localparam logic [11:0] OFS_UPD_CTRL = 12'h214;
  localparam logic [11:0] GRP_SPAN = 12'h080;

  // Move configuration fields
  localparam int MV_DIST_LSB = 16;
  localparam int MV_ROWS_LSB = 0;
  localparam logic [31:0] MV_CFG_RST = 32'h0000_0000;

  // Update control fields
  localparam int CTRL_CMD_LSB = 22;
  localparam int CTRL_ENTRY_DIS = 21;
  localparam int CTRL_ACTION_DIS = 20;
  localparam int CTRL_CNT_DIS = 19;
  localparam int CTRL_ADDR_LSB = 3;
  localparam int CTRL_SHOT = 2;
  localparam int CTRL_CLEAR = 1;
  localparam logic [31:0] UPD_CTRL_RST = 32'h0000_0000;

  // Update commands
  localparam logic [2:0] CMD_TO_MEM = 3'h0;
  localparam logic [2:0] CMD_FROM_MEM = 3'h1;
  localparam logic [2:0] CMD_MOVE_UP = 3'h2;
  localparam logic [2:0] CMD_MOVE_DOWN = 3'h3;
  localparam logic [2:0] CMD_INIT = 3'h4;

  // Register region selectors
  localparam logic [2:0] SEL_ENTRY = 3'h0;
  localparam logic [2:0] SEL_MASK = 3'h1;
  localparam logic [2:0] SEL_ACTION = 3'h2;
  localparam logic [2:0] SEL_CNT = 3'h3;
  localparam logic [2:0] SEL_TG = 3'h4;
  localparam logic [2:0] SEL_MV = 3'h5;
  localparam logic [2:0] SEL_CTRL = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} rtc_state_t;

endpackage : rtc_pkg

// ==== rtl/rtc_cache_bank.sv ====
// One cache holding only its physical width, read and written as words
`timescale 1ns/1ns
module rtc_cache_bank #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic ld_en,
  input wire logic [W-1:0] ld_data,
  input wire logic clr,
  input wire logic [4:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [W-1:0] value
);

  logic [W-1:0] val_r;
  logic [W-1:0] val_nxt;
  logic [W+1023:0] pad;

  // Bits above W read as zero
  assign pad = {1024'h0, val_r};
  assign rd_data = pad[32*rd_idx +: 32];
  assign value = val_r;

  // Flops exist only for the physical width
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign val_nxt[b] = ld_en ? ld_data[b] :
      (wr_en && wr_idx == 5'(b / 32) && wr_strb[(b % 32) / 8]) ?
      wr_data[b % 32] : val_r[b];
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      val_r <= '0;
    end else begin
      val_r <= val_nxt;
    end
  end

endmodule : rtc_cache_bank

// ==== sim/rtc_rule_table_cache_asserts.sv ====
// Assertions on the APB port of the rule table cache block
`timescale 1ns/1ns
module rtc_rule_table_cache_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire misal = paddr[1:0] != 2'b00;
  wire unmapped = (paddr > 12'h200 && paddr < 12'h210) || paddr > 12'h214;
  wire rd_done = pready && !pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    penable && !pready ##1 penable && pready;
  endsequence
  ////////////////////////////////////////
  chk_one_wait: assert property (s_setup |=> s_access)
    else $error("access phase not two cycles");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_quiet_reset: assert property ($fell(sys_rst) |-> !pready)
    else $error("pready right after reset");
  chk_bad_addr: assert property (pready && (misal || unmapped) |-> pslverr)
    else $error("bad address not refused");
  chk_good_addr: assert property (pready && !misal && !unmapped |-> !pslverr)
    else $error("mapped address refused");
  chk_upper_zero: assert property (rd_done && paddr[11:8] == 4'h0 &&
    paddr[6:3] != 4'h0 |-> prdata == 32'h0)
    else $error("entry or mask word above width not zero");
  chk_cnt_upper: assert property (rd_done && paddr[11:7] == 5'h3 &&
    paddr[6:2] != 5'h0 |-> prdata == 32'h0)
    else $error("counter word above width not zero");
  chk_rdata_idle: assert property (!rd_done |-> prdata == 32'h0)
    else $error("read data outside read answer");
  chk_err_pairs: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
endmodule : rtc_rule_table_cache_asserts

bind rtc_rule_table_cache rtc_rule_table_cache_asserts u_chk (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ==== sim/testbench.sv ====
// Self-checking bench for the rule table cache block
`timescale 1ns/1ns
module testbench;
  import rtc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  logic [2:0] dis = 3'h0;
  localparam logic [31:0] X = 32'h0000_00aa;
  localparam logic [31:0] Y = 32'h0000_00bb;
  localparam logic [31:0] P = 32'h0000_00cc;

  rtc_rule_table_cache dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(q, exp);
  endtask : rd

  // Start one update and poll the trigger bit until it drops
  task automatic run_op(input logic [2:0] c, input logic [15:0] a);
    int n;
    n = 0;
    wr(OFS_UPD_CTRL, {7'h0, c, dis, a, 3'h4});
    do begin
      apb(1'b0, OFS_UPD_CTRL, 32'h0, 4'h0);
      n++;
    end while (q[CTRL_SHOT] !== 1'b0 && n < 50);
    chk(q & 32'h4, 32'h0);
  endtask : run_op

  task automatic set_cache(input logic [31:0] v);
    wr(OFS_ENTRY, v);
    wr(OFS_ACTION, v);
    wr(OFS_CNT, v);
  endtask : set_cache

  task automatic row_chk(input logic [15:0] a, input logic [31:0] v);
    run_op(CMD_FROM_MEM, a);
    rd(OFS_ENTRY, v);
    rd(OFS_ACTION, v);
    rd(OFS_CNT, v);
  endtask : row_chk
  ////////////////////////////////////////
  task automatic t_reset_vals();
    for (int i = 0; i < 129; i++) rd(12'(i * 4), 32'h0);
    rd(OFS_MV_CFG, 32'h0);
  endtask : t_reset_vals

  task automatic t_cache_rw();
    logic [11:0] b;
    for (int g = 0; g < 4; g++) begin
      b = OFS_ENTRY + 12'(g * 128);
      wr(b, 32'h1000_0001 + 32'(g));
      wr(b + 12'h4, 32'h2000_0002 + 32'(g));
      wr(b + 12'h8, 32'hffff_ffff);
      rd(b, 32'h1000_0001 + 32'(g));
      rd(b + 12'h4, (g == 3) ? 32'h0 : 32'h2000_0002 + 32'(g));
      rd(b + 12'h8, 32'h0);
    end
    wr(OFS_TG, 32'hdead_beef);
    rd(OFS_TG, 32'hdead_beef);
    apb(1'b1, OFS_TG, 32'h1234_5678, 4'h1);
    rd(OFS_TG, 32'hdead_be78);
    wr(OFS_UPD_CTRL, 32'h2);
    rd(OFS_ENTRY, 32'h0);
    rd(OFS_TG, 32'h0);
  endtask : t_cache_rw

  task automatic t_bad_addr();
    apb(1'b0, 12'h204, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h002, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h218, 32'h5, 4'hf);
    chk({31'h0, e}, 32'h1);
    wr(OFS_MV_CFG, 32'h0003_0002);
    rd(OFS_MV_CFG, 32'h0003_0002);
  endtask : t_bad_addr

  task automatic t_init();
    set_cache(X);
    wr(OFS_MV_CFG, 32'h0000_000f);
    run_op(CMD_INIT, 16'h0);
    set_cache(Y);
    wr(OFS_MV_CFG, 32'h0000_0002);
    run_op(CMD_INIT, 16'h5);
    row_chk(16'h4, X);
    row_chk(16'h5, Y);
    row_chk(16'h7, Y);
    row_chk(16'h8, X);
  endtask : t_init

  task automatic t_move();
    set_cache(P);
    run_op(CMD_TO_MEM, 16'h2);
    wr(OFS_MV_CFG, 32'h0001_0000);
    run_op(CMD_MOVE_DOWN, 16'h2);
    row_chk(16'h4, P);
    row_chk(16'h3, X);
    wr(OFS_MV_CFG, 32'h0000_0001);
    run_op(CMD_MOVE_UP, 16'h4);
    row_chk(16'h3, P);
    row_chk(16'h4, Y);
    wr(OFS_MV_CFG, 32'h0002_0000);
    run_op(CMD_MOVE_UP, 16'h1);
    run_op(CMD_FROM_MEM, 16'h1);
    rd(OFS_ACTION, 32'h0);
    rd(OFS_CNT, 32'h0);
    row_chk(16'h0, X);
  endtask : t_move

  task automatic t_bad_cmds();
    for (int c = 5; c < 8; c++) run_op(3'(c), 16'h0);
    row_chk(16'h0, X);
  endtask : t_bad_cmds

  // Copy with the action lane disabled leaves the action row alone
  task automatic t_dis();
    set_cache(P);
    dis = 3'h2;
    run_op(CMD_TO_MEM, 16'h0);
    dis = 3'h0;
    run_op(CMD_FROM_MEM, 16'h0);
    rd(OFS_ENTRY, P);
    rd(OFS_ACTION, X);
    rd(OFS_CNT, P);
  endtask : t_dis

  // Reset in mid-run after the registers hold nonzero values
  task automatic t_mid_reset();
    wr(OFS_MV_CFG, 32'h1234_5678);
    wr(OFS_MASK, 32'h0000_0055);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFS_MV_CFG, 32'h0);
    rd(OFS_MASK, 32'h0);
    rd(OFS_ACTION, 32'h0);
  endtask : t_mid_reset
  ////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_vals();
    t_cache_rw();
    t_bad_addr();
    t_init();
    t_move();
    t_bad_cmds();
    t_dis();
    t_mid_reset();
    print_verdict();
  end
endmodule : testbench
